// *** design/psbps_consts.vh ***
`ifndef PSBPS_CONSTS_VH
`define PSBPS_CONSTS_VH

// Interface modes
`define PSBPS_MODE_UL2 2'h0
`define PSBPS_MODE_UL3 2'h1
`define PSBPS_MODE_PL2 2'h2
`define PSBPS_MODE_PL3 2'h3

// Bus widths
`define PSBPS_BW_8 2'h0
`define PSBPS_BW_16 2'h1
`define PSBPS_BW_32 2'h2

// Geometry defaults
`define PSBPS_NPORT 4
`define PSBPS_ADDR_W 5
`define PSBPS_DATA_W 32

// Byte modulus codes
`define PSBPS_MOD_ALL 2'h0
`define PSBPS_MOD_BIT_HI 1
`define PSBPS_MOD_BIT_LO 0

// Timing
`define PSBPS_SYS_CLK_NS 10
`define PSBPS_LINK_CLK_NS 125

// Reset values
`define PSBPS_PORT_RST 5'h00

`endif

// *** design/psbps_buf.v ***
`timescale 1ns/10ps
// Two-entry skid buffer with registered outputs
module psbps_buf #(
	parameter W = 8
) (
	input wire clk_sys_in,
	input wire nrst_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [W-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [W-1:0] out_data_out
);
	reg [W-1:0] head_q;
	reg head_valid_q;
	reg [W-1:0] skid_q;
	reg skid_valid_q;
	wire push;
	wire free;

	assign push = in_valid_in & ~skid_valid_q;
	assign free = out_ready_in | ~head_valid_q;
	assign in_ready_out = ~skid_valid_q;
	assign out_valid_out = head_valid_q;
	assign out_data_out = head_q;

	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			head_q <= {W{1'b0}};
			head_valid_q <= 1'b0;
			skid_q <= {W{1'b0}};
			skid_valid_q <= 1'b0;
		end else if (free) begin
			if (skid_valid_q) begin
				head_q <= skid_q;
				head_valid_q <= 1'b1;
				skid_valid_q <= 1'b0;
			end else begin
				head_q <= in_data_in;
				head_valid_q <= push;
			end
		end else if (push) begin
			skid_q <= in_data_in;
			skid_valid_q <= 1'b1;
		end
	end
endmodule

// *** design/psbps_top.v ***
`timescale 1ns/10ps
`include "psbps_consts.vh"

// Summary of operation
// RULE1 - Link level 3 cell mode: selected-available output driven low constantly.
// RULE2 - Level-2 packet mode: drive output only while enabled, selected, not in reset.
// RULE3 - Link level 2 cell mode, the reset default: selected-available output floats.
// RULE4 - Link marks last transfer of each packet with end-of-packet, sampled rising edge.
// RULE5 - Cell modes ignore end-of-packet completely.
// RULE6 - Level 3 packet mode: start-of-transfer precedes data, data bus holds port address.
// RULE7 - After start-of-transfer falls, transfers go to captured in-band port.
// RULE8 - Start-of-transfer counts only while transmit enable pin is high.
// RULE9 - All modes except level 3 packet ignore start-of-transfer.
// RULE10 - Modulus 00 all bytes, 01 upper three, 10 upper two, 11 top byte.
// RULE11 - Modulus is evaluated only with end-of-packet, else treated as zero.
// RULE12 - Sixteen-bit bus in packet modes ignores modulus upper bit.
// RULE13 - Eight-bit bus, and all cell modes, ignore both modulus bits.
// RULE14 - Error on end-of-packet transfer aborts the packet in packet modes.
// RULE15 - Error sampled only with end-of-packet; ignored in cell modes.
// RULE16 - Link drives five-bit receive address, top bit first, on receive clock; code samples all five bits in parallel on one edge.
// RULE17 - Level 3 packet mode ignores the receive address bus.
// RULE18 - All receive signals are sampled on the receive clock's rising edges.
// RULE19 - Captured in-band port holds across idle cycles until next start-of-transfer.
module psbps_top #(
	parameter NPORT = `PSBPS_NPORT,
	parameter ADDR_W = `PSBPS_ADDR_W,
	parameter DATA_W = `PSBPS_DATA_W
) (
	input wire clk_sys_in,
	input wire nrst_in,
	input wire [1:0] mode_in,
	input wire [1:0] bus_width_in,
	input wire dp_reset_in,
	input wire tx_system_clock_in,
	input wire tx_enable_n_in,
	input wire tx_start_of_transfer_in,
	input wire tx_end_of_packet_in,
	input wire [1:0] tx_byte_modulus_in,
	input wire tx_packet_error_in,
	input wire [DATA_W-1:0] tx_data_in,
	input wire [ADDR_W-1:0] tx_port_address_in,
	input wire [NPORT-1:0] port_can_accept_in,
	output reg tx_selected_pkt_avail_out,
	output reg tx_selected_pkt_avail_oe_out,
	output wire word_valid_out,
	input wire word_ready_in,
	output wire [DATA_W-1:0] word_data_out,
	output wire [ADDR_W-1:0] word_port_out,
	output wire word_sop_out,
	output wire word_eop_out,
	output wire [1:0] word_modulus_out,
	output wire word_abort_out,
	output reg tx_overflow_out,
	output reg [ADDR_W-1:0] tx_port_out,
	input wire rx_system_clock_in,
	input wire [ADDR_W-1:0] rx_port_address_in,
	output reg [ADDR_W-1:0] rx_port_sel_out,
	output reg rx_port_sel_valid_out
);
	localparam TXW = DATA_W + ADDR_W + 6;
	localparam BW = DATA_W + ADDR_W + 5;
	localparam [ADDR_W-1:0] NPORT_A = NPORT;

	// One-hot transmit sequencing states
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_ADDR = 3'h2;
	localparam [2:0] ST_DATA = 3'h4;

	// Pin synchronisers: two stages, plus one for pre-edge data
	reg [1:0] txc_s_q;
	reg txc_prev_q;
	reg [1:0] rxc_s_q;
	reg rxc_prev_q;
	reg [TXW-1:0] txp_s1_q;
	reg [TXW-1:0] txp_s2_q;
	reg [TXW-1:0] txp_s3_q;
	reg [ADDR_W-1:0] rxa_s1_q;
	reg [ADDR_W-1:0] rxa_s2_q;
	reg [ADDR_W-1:0] rxa_s3_q;

	wire tx_edge;
	wire rx_edge;
	wire [TXW-1:0] txp_bundle;

	assign txp_bundle = {tx_enable_n_in, tx_start_of_transfer_in, tx_end_of_packet_in,
		tx_byte_modulus_in, tx_packet_error_in, tx_data_in, tx_port_address_in};

	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			txc_s_q <= 2'h0;
			txc_prev_q <= 1'b0;
			rxc_s_q <= 2'h0;
			rxc_prev_q <= 1'b0;
			txp_s1_q <= {TXW{1'b0}};
			txp_s2_q <= {TXW{1'b0}};
			txp_s3_q <= {TXW{1'b0}};
			rxa_s1_q <= {ADDR_W{1'b0}};
			rxa_s2_q <= {ADDR_W{1'b0}};
			rxa_s3_q <= {ADDR_W{1'b0}};
		end else begin
			txc_s_q <= {txc_s_q[0], tx_system_clock_in};
			txc_prev_q <= txc_s_q[1];
			rxc_s_q <= {rxc_s_q[0], rx_system_clock_in};
			rxc_prev_q <= rxc_s_q[1];
			txp_s1_q <= txp_bundle;
			txp_s2_q <= txp_s1_q;
			txp_s3_q <= txp_s2_q;
			rxa_s1_q <= rx_port_address_in;
			rxa_s2_q <= rxa_s1_q;
			rxa_s3_q <= rxa_s2_q;
		end
	end

	assign tx_edge = txc_s_q[1] & ~txc_prev_q;
	assign rx_edge = rxc_s_q[1] & ~rxc_prev_q;

	// Sampled transmit pins, as they stood before the edge
	wire ten_n;
	wire tx_start_of_transfer;
	wire tx_end_of_packet;
	wire [1:0] tx_byte_modulus;
	wire tx_packet_error;
	wire [DATA_W-1:0] tdata;
	wire [ADDR_W-1:0] tadr;

	assign {ten_n, tx_start_of_transfer, tx_end_of_packet, tx_byte_modulus, tx_packet_error, tdata, tadr} = txp_s3_q;

	// Mode decode
	wire pkt_mode;
	wire spi3_mode;
	wire pl2_mode;
	wire ul3_mode;

	assign pkt_mode = (mode_in == `PSBPS_MODE_PL2) | (mode_in == `PSBPS_MODE_PL3);
	assign spi3_mode = (mode_in == `PSBPS_MODE_PL3);
	assign pl2_mode = (mode_in == `PSBPS_MODE_PL2);
	assign ul3_mode = (mode_in == `PSBPS_MODE_UL3);

	// Qualified transfer attributes
	wire xfer;
	wire eop_q;
	wire err_q;
	reg [1:0] mod_eff;
	wire tsx_q;

	assign xfer = tx_edge & ~ten_n & ~dp_reset_in;
	assign eop_q = pkt_mode & tx_end_of_packet; // [RULE5] [RULE4]
	assign err_q = eop_q & tx_packet_error; // [RULE15] [RULE14]
	assign tsx_q = spi3_mode & tx_start_of_transfer & ten_n; // [RULE8] [RULE9]

	always @* begin
		mod_eff = `PSBPS_MOD_ALL;
		if (eop_q) begin // [RULE11]
			case (bus_width_in)
				`PSBPS_BW_32: mod_eff = tx_byte_modulus; // [RULE10]
				`PSBPS_BW_16: mod_eff = {1'b0, tx_byte_modulus[`PSBPS_MOD_BIT_LO]}; // [RULE12]
				default: mod_eff = `PSBPS_MOD_ALL; // [RULE13]
			endcase
		end
	end

	// Port selection and in-band address tracking
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [ADDR_W-1:0] pend_addr_q;
	reg [ADDR_W-1:0] port_q;
	reg sel_valid_q;
	reg in_pkt_q;

	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (tx_edge && tsx_q) begin
					st_d = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (tx_edge && !tsx_q) begin
					st_d = ST_DATA;
				end
			end
			ST_DATA: begin
				if (tx_edge && tsx_q) begin
					st_d = ST_ADDR;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (!spi3_mode || dp_reset_in) begin
			st_d = ST_IDLE;
		end
	end

	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			st_q <= ST_IDLE;
			pend_addr_q <= `PSBPS_PORT_RST;
			port_q <= `PSBPS_PORT_RST;
			sel_valid_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (dp_reset_in) begin
				sel_valid_q <= 1'b0;
			end else if (spi3_mode) begin
				if (tx_edge && tsx_q) begin
					pend_addr_q <= tdata[ADDR_W-1:0]; // [RULE6]
				end
				if (st_q == ST_ADDR && st_d == ST_DATA) begin
					port_q <= pend_addr_q; // [RULE7] [RULE19]
					sel_valid_q <= (pend_addr_q < NPORT_A);
				end
			end else if (tx_edge && ten_n) begin
				port_q <= tadr;
				sel_valid_q <= (tadr < NPORT_A);
			end
		end
	end

	// Packet framing for start-of-packet marking
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			in_pkt_q <= 1'b0;
		end else if (dp_reset_in || !pkt_mode) begin
			in_pkt_q <= 1'b0;
		end else if (xfer) begin
			in_pkt_q <= ~eop_q;
		end
	end

	// Word buffer toward the core
	wire buf_in_ready;
	wire buf_push;
	wire [BW-1:0] buf_in;
	wire [BW-1:0] buf_out;
	wire first_data;

	// First data after the address cycle goes straight to the new port
	assign first_data = (st_q == ST_ADDR) & (st_d == ST_DATA);
	assign buf_push = xfer & (~spi3_mode | (st_q == ST_DATA) | first_data); // [RULE7]
	assign buf_in = {tdata, first_data ? pend_addr_q : port_q, ~in_pkt_q, eop_q, mod_eff, err_q};

	psbps_buf #(
		.W(BW)
	) u_buf (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.in_valid_in(buf_push),
		.in_ready_out(buf_in_ready),
		.in_data_in(buf_in),
		.out_valid_out(word_valid_out),
		.out_ready_in(word_ready_in),
		.out_data_out(buf_out)
	);

	assign {word_data_out, word_port_out, word_sop_out, word_eop_out, word_modulus_out,
		word_abort_out} = buf_out;

	// Word lost when buffer was full; sticky until reset
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			tx_overflow_out <= 1'b0;
		end else if (buf_push && !buf_in_ready) begin
			tx_overflow_out <= 1'b1;
		end
	end

	// Selected-port availability pin
	wire sel_ready;

	assign sel_ready = sel_valid_q & port_can_accept_in[port_q[1:0]] & buf_in_ready;

	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			tx_selected_pkt_avail_out <= 1'b0;
			tx_selected_pkt_avail_oe_out <= 1'b0;
			tx_port_out <= `PSBPS_PORT_RST;
		end else begin
			tx_port_out <= port_q;
			if (ul3_mode) begin
				tx_selected_pkt_avail_out <= 1'b0; // [RULE1]
				tx_selected_pkt_avail_oe_out <= 1'b1; // [RULE1]
			end else if (pl2_mode) begin
				if (dp_reset_in || !sel_valid_q || ten_n) begin
					tx_selected_pkt_avail_oe_out <= 1'b0; // [RULE2]
					tx_selected_pkt_avail_out <= 1'b0;
				end else begin
					tx_selected_pkt_avail_oe_out <= 1'b1; // [RULE2]
					if (tx_edge) begin
						tx_selected_pkt_avail_out <= sel_ready;
					end
				end
			end else if (spi3_mode) begin
				tx_selected_pkt_avail_oe_out <= 1'b1;
				if (tx_edge) begin
					tx_selected_pkt_avail_out <= sel_ready;
				end
			end else begin
				tx_selected_pkt_avail_out <= 1'b0;
				tx_selected_pkt_avail_oe_out <= 1'b0; // [RULE3]
			end
		end
	end

	// Receive port address, taken on receive clock edges
	always @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			rx_port_sel_out <= `PSBPS_PORT_RST;
			rx_port_sel_valid_out <= 1'b0;
		end else if (rx_edge && !spi3_mode) begin // [RULE18] [RULE17]
			rx_port_sel_out <= rxa_s3_q; // [RULE16]
			rx_port_sel_valid_out <= (rxa_s3_q < NPORT_A);
		end
	end
endmodule

// *** verif/psbps_assertions.sv ***
`timescale 1ns/10ps
module psbps_checker (
	input wire clk_sys_in,
	input wire nrst_in,
	input wire [1:0] mode_in,
	input wire [1:0] bus_width_in,
	input wire dp_reset_in,
	input wire word_valid_out,
	input wire word_ready_in,
	input wire [31:0] word_data_out,
	input wire word_eop_out,
	input wire [1:0] word_modulus_out,
	input wire word_abort_out,
	input wire tx_overflow_out,
	input wire tx_selected_pkt_avail_out,
	input wire tx_selected_pkt_avail_oe_out,
	input wire [4:0] rx_port_sel_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);
	a_ul3_pin_low: assert property (mode_in == 2'h1 [*3] |->
		tx_selected_pkt_avail_oe_out && !tx_selected_pkt_avail_out) else $error("pin not driven low");
	a_pl2_rst_float: assert property ((mode_in == 2'h2 && dp_reset_in) [*2] |->
		!tx_selected_pkt_avail_oe_out) else $error("pin driven in data path reset");
	a_ul2_float: assert property (mode_in == 2'h0 [*2] |-> !tx_selected_pkt_avail_oe_out)
		else $error("pin driven in cell level 2");
	a_cell_no_eop: assert property (word_valid_out && !mode_in[1] |-> !word_eop_out)
		else $error("end flag in cell mode");
	a_cell_no_err: assert property (word_valid_out && !mode_in[1] |-> !word_abort_out)
		else $error("abort in cell mode");
	a_cell_no_mod: assert property (word_valid_out && !mode_in[1] |-> word_modulus_out == 2'h0)
		else $error("modulus in cell mode");
	a_w16_mod_hi: assert property (word_valid_out && mode_in[1] && bus_width_in == 2'h1 |->
		!word_modulus_out[1]) else $error("modulus upper bit kept");
	a_mod_eop_only: assert property (word_valid_out && !word_eop_out |->
		word_modulus_out == 2'h0 && !word_abort_out) else $error("modulus without end flag");
	a_rx_l3_ignore: assert property (mode_in == 2'h3 [*5] |=> $stable(rx_port_sel_out))
		else $error("rx address taken in mode 3");
	a_ovf_sticky: assert property (tx_overflow_out |=> tx_overflow_out) else $error("overflow cleared");
	a_word_hold: assert property (word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_data_out))
		else $error("word lost in stall");
	cover property (word_valid_out && word_ready_in && word_eop_out);
	cover property (tx_overflow_out);
	cover property (tx_selected_pkt_avail_oe_out && mode_in == 2'h2);
endmodule
bind psbps_top psbps_checker u_psbps_checker (.clk_sys_in, .nrst_in, .mode_in, .bus_width_in, .dp_reset_in,
	.word_valid_out, .word_ready_in, .word_data_out, .word_eop_out, .word_modulus_out, .word_abort_out,
	.tx_overflow_out, .tx_selected_pkt_avail_out, .tx_selected_pkt_avail_oe_out, .rx_port_sel_out);

// *** verif/psbps_link.sv ***
`timescale 1ns/10ps
module psbps_link (
	output reg tx_clk_out,
	output reg rx_clk_out,
	output reg [5:0] ctl_out,
	output reg [31:0] data_out,
	output reg [4:0] rx_addr_out
);
	initial begin
		tx_clk_out = 1'b0;
		ctl_out = 6'h20;
		data_out = 32'h0;
		rx_addr_out = 5'h00;
		forever #62.5 tx_clk_out = ~tx_clk_out;
	end
	initial begin
		rx_clk_out = 1'b0;
		#31;
		forever #62.5 rx_clk_out = ~rx_clk_out;
	end
	// Ctl is {enable_n, start, end, modulus, error}; held through the rising edge
	task send(input logic [5:0] c, input logic [31:0] d);
		@(negedge tx_clk_out);
		#1;
		ctl_out = c;
		data_out = d;
		@(posedge tx_clk_out);
	endtask
	task set_rx(input logic [4:0] a);
		@(negedge rx_clk_out);
		rx_addr_out = a;
		repeat (2) @(posedge rx_clk_out);
	endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/10ps
module testbench;
	reg clk, nrst, dp_rst, ready;
	reg [1:0] mode, bw;
	reg [4:0] tpa;
	reg [3:0] room;
	wire tck, rck, pa, pa_oe, wv, we, wa, ovf, ws, rv;
	wire [5:0] ctl;
	wire [31:0] dat, wd;
	wire [4:0] rx_port_address, wp, rsel, tp;
	wire [1:0] wm;
	integer fail_count = 0;
	integer cmp_count = 0;
	integer i;
	logic got;
	psbps_link u_psbps_link (.tx_clk_out(tck), .rx_clk_out(rck), .ctl_out(ctl), .data_out(dat), .rx_addr_out(rx_port_address));
	psbps_top u_psbps_top (.clk_sys_in(clk), .nrst_in(nrst), .mode_in(mode), .bus_width_in(bw), .dp_reset_in(dp_rst),
		.tx_system_clock_in(tck), .tx_enable_n_in(ctl[5]), .tx_start_of_transfer_in(ctl[4]),
		.tx_end_of_packet_in(ctl[3]), .tx_byte_modulus_in(ctl[2:1]), .tx_packet_error_in(ctl[0]),
		.tx_data_in(dat), .tx_port_address_in(tpa), .port_can_accept_in(room), .tx_selected_pkt_avail_out(pa),
		.tx_selected_pkt_avail_oe_out(pa_oe), .word_valid_out(wv), .word_ready_in(ready), .word_data_out(wd),
		.word_port_out(wp), .word_sop_out(ws), .word_eop_out(we), .word_modulus_out(wm), .word_abort_out(wa),
		.tx_overflow_out(ovf), .tx_port_out(tp), .rx_system_clock_in(rck), .rx_port_address_in(rx_port_address),
		.rx_port_sel_out(rsel), .rx_port_sel_valid_out(rv));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task get_w;
		got = 1'b0;
		for (i = 0; i < 30 && !got; i++) begin
			@(posedge clk);
			#1;
			got = (wv === 1'b1);
		end
		chk("word_valid", 1, got);
	endtask
	task set_mode(input logic [1:0] m, input logic [1:0] w);
		@(posedge clk);
		#1;
		mode = m;
		bw = w;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task t_pin;
		chk("pin_oe", 0, pa_oe);
		set_mode(2'h1, 2'h2);
		chk("pin_oe", 1, pa_oe);
		chk("pin", 0, pa);
		dp_rst = 1'b1;
		set_mode(2'h2, 2'h2);
		chk("pin_oe", 0, pa_oe);
		dp_rst = 1'b0;
	endtask
	task t_spi3;
		set_mode(2'h3, 2'h2);
		u_psbps_link.send(6'h30, 32'h2);
		for (int m = 0; m < 4; m++) begin
			u_psbps_link.send({3'b001, m[1:0], 1'b0}, 32'h5a00 + m);
			get_w;
			chk("port", 2, wp);
			chk("data", 32'h5a00 + m, wd);
			chk("eop", 1, we);
			chk("mod", m, wm);
			chk("sop", 1, ws);
		end
		u_psbps_link.send(6'h20, 32'h1);
		u_psbps_link.send(6'h10, 32'h3);
		get_w;
		chk("port", 2, wp);
		chk("tx_port", 2, tp);
		u_psbps_link.send(6'h20, 32'h0);
	endtask
	task t_pl2;
		set_mode(2'h2, 2'h1);
		tpa = 5'h01;
		u_psbps_link.send(6'h20, 32'h0);
		u_psbps_link.send(6'h07, 32'h11);
		get_w;
		chk("mod", 0, wm);
		chk("abort", 0, wa);
		chk("port", 1, wp);
		chk("pin_oe", 1, pa_oe);
		chk("pin", 1, pa);
		u_psbps_link.send(6'h0f, 32'h12);
		get_w;
		chk("mod", 1, wm);
		chk("abort", 1, wa);
		set_mode(2'h2, 2'h0);
		u_psbps_link.send(6'h0e, 32'h13);
		get_w;
		chk("mod", 0, wm);
		set_mode(2'h0, 2'h2);
		u_psbps_link.send(6'h1f, 32'h3);
		get_w;
		chk("eop", 0, we);
		chk("abort", 0, wa);
		chk("mod", 0, wm);
		chk("port", 1, wp);
		u_psbps_link.send(6'h20, 32'h0);
	endtask
	task t_rx;
		set_mode(2'h2, 2'h2);
		u_psbps_link.set_rx(5'h13);
		repeat (6) @(posedge clk);
		#1;
		chk("rx_sel", 5'h13, rsel);
		chk("rx_valid", 0, rv);
		set_mode(2'h3, 2'h2);
		u_psbps_link.set_rx(5'h04);
		repeat (6) @(posedge clk);
		#1;
		chk("rx_sel", 5'h13, rsel);
	endtask
	task t_full;
		set_mode(2'h2, 2'h2);
		ready = 1'b0;
		for (int k = 0; k < 4; k++) u_psbps_link.send(6'h00, 32'h70 + k);
		u_psbps_link.send(6'h20, 32'h0);
		chk("overflow", 1, ovf);
		chk("head", 32'h70, wd);
		@(posedge clk);
		#1;
		ready = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk("empty", 0, wv);
	endtask
	task close_out;
		$display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		fail_count++;
		close_out;
	end
	initial begin
		{nrst, dp_rst, ready, mode, bw, tpa, room} = {3'b001, 2'h0, 2'h2, 5'h00, 4'hf};
		repeat (3) @(posedge clk);
		#1;
		nrst = 1'b1;
		repeat (5) @(posedge clk);
		t_pin;
		t_spi3;
		t_pl2;
		t_rx;
		t_full;
		close_out;
	end
endmodule
